// *** common/pcl_defs.svh ***
// Constants for the program counter load logic.
// Assumes inclusion by bare name from design files.
`ifndef PCL_DEFS_SVH
`define PCL_DEFS_SVH
`define PCL_PC_WIDTH 13
`define PCL_LOW_WIDTH 8
`define PCL_UPPER_WIDTH 5
`define PCL_PAGE_LSB 11
`define PCL_PC_RESET 13'h0000
`define PCL_LATCH_RESET 8'h00
`define PCL_PMEM_WORDS 8192
`define PCL_SMALL_MEM_WORDS 4096
`endif

// *** common/pcl_pkg.sv ***
// Types for the program counter load logic.
// Assumes the core decoder drives one operation per fetch cycle.
package pcl_pkg;
  typedef enum logic [2:0] {
    PCL_OP_NONE = 3'h0,
    PCL_OP_INC = 3'h1,
    PCL_OP_WRLOW = 3'h3,
    PCL_OP_JUMP = 3'h2,
    PCL_OP_CALL = 3'h6,
    PCL_OP_RET = 3'h7,
    PCL_OP_INTR = 3'h5
  } pcl_op_type;

  typedef struct packed {
    pcl_op_type op;
    logic [7:0] low_data;
    logic [10:0] target;
    logic [12:0] ret_addr;
    logic [12:0] vector;
  } pcl_req_type;
endpackage

// *** hdl/pcl_counter.sv ***
// Program counter with low-byte register access and latch-driven upper bits.
// Assumes decoder presents one op per enabled cycle; stack is outside.
// Operation
// - Program counter is one 13-bit register
// - Low byte readable and writable by software
// - Upper bits unreadable, loaded from latch, jump or call target, return address, vector or increment carry
// - Any reset clears upper counter bits
// - Low write copies latch bits 4:0 upward
// - Jump or call takes latch bits 4:3
// - Jump or call loads low eleven bits
// - Call or interrupt pushes full counter; return pops
// - Small-memory variants ignore latch bit four
// - Push and pop leave latch untouched
`timescale 1ns/1ps
`include "pcl_defs.svh"
module pcl_counter #(
  parameter int PMEM_WORDS = `PCL_PMEM_WORDS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire pcl_pkg::pcl_req_type req,
  input wire logic [7:0] upper_latch,
  output logic [`PCL_PC_WIDTH-1:0] program_counter,
  output logic [`PCL_LOW_WIDTH-1:0] pc_low_byte,
  output logic push_valid,
  output logic [`PCL_PC_WIDTH-1:0] push_data,
  output logic pop_valid
);
  // -------------------------------------------------------------------
  // Latch view
  // -------------------------------------------------------------------
  // mask page bit four
  function automatic logic [4:0] latch_bits(input logic [7:0] lat);
    logic [4:0] v;
    v = lat[4:0];
    if (PMEM_WORDS <= `PCL_SMALL_MEM_WORDS) begin
      v[4] = 1'b0;
    end
    return v;
  endfunction

  // Ops that save the counter on the return stack
  function automatic logic push_op(input pcl_pkg::pcl_op_type op);
    return (op == pcl_pkg::PCL_OP_CALL) || (op == pcl_pkg::PCL_OP_INTR);
  endfunction

  logic [4:0] lat5;
  logic [`PCL_PC_WIDTH-1:0] next_pc;
  assign lat5 = latch_bits(upper_latch);

  // -------------------------------------------------------------------
  // Next counter value
  // -------------------------------------------------------------------
  always_comb begin
    next_pc = program_counter;
    unique case (req.op)
      pcl_pkg::PCL_OP_WRLOW: next_pc = {lat5, req.low_data};
      pcl_pkg::PCL_OP_JUMP,
      pcl_pkg::PCL_OP_CALL: next_pc = {lat5[4:3], req.target};
      pcl_pkg::PCL_OP_RET: next_pc = req.ret_addr;
      pcl_pkg::PCL_OP_INTR: next_pc = req.vector;
      pcl_pkg::PCL_OP_INC: next_pc = program_counter + 13'h0001;
      pcl_pkg::PCL_OP_NONE: next_pc = program_counter;
      default: next_pc = program_counter;
    endcase
  end

  // -------------------------------------------------------------------
  // Counter register
  // -------------------------------------------------------------------
  // single counter register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      program_counter <= `PCL_PC_RESET;
    end else if (clk_en) begin
      program_counter <= next_pc;
    end
  end

  assign pc_low_byte = program_counter[7:0];

  // -------------------------------------------------------------------
  // Stack side
  // -------------------------------------------------------------------
  // push full return address
  // latch is an input only, never written here
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      push_valid <= 1'b0;
      push_data <= `PCL_PC_RESET;
      pop_valid <= 1'b0;
    end else if (clk_en) begin
      push_valid <= push_op(req.op);
      push_data <= program_counter;
      pop_valid <= (req.op == pcl_pkg::PCL_OP_RET);
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  sequence s_wrlow;
    clk_en && req.op == pcl_pkg::PCL_OP_WRLOW;
  endsequence
  sequence s_jump;
    clk_en && req.op == pcl_pkg::PCL_OP_JUMP;
  endsequence
  sequence s_call;
    clk_en && req.op == pcl_pkg::PCL_OP_CALL;
  endsequence
  sequence s_ret;
    clk_en && req.op == pcl_pkg::PCL_OP_RET;
  endsequence
  sequence s_intr;
    clk_en && req.op == pcl_pkg::PCL_OP_INTR;
  endsequence
  sequence s_inc;
    clk_en && req.op == pcl_pkg::PCL_OP_INC;
  endsequence
  // Enabled ops that must leave both stack strobes low
  sequence s_quiet;
    clk_en && !push_op(req.op) && req.op != pcl_pkg::PCL_OP_RET;
  endsequence

  a_low_write_load: assert property (@(posedge clk) disable iff (!resetn)
    s_wrlow |=> program_counter == {$past(lat5), $past(req.low_data)})
    else $error("low write load wrong");
  a_jump_target: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && (req.op == pcl_pkg::PCL_OP_JUMP || req.op == pcl_pkg::PCL_OP_CALL)
    |=> program_counter[10:0] == $past(req.target))
    else $error("jump target wrong");
  a_jump_page: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && req.op == pcl_pkg::PCL_OP_JUMP |=> program_counter[12:11] == $past(lat5[4:3]))
    else $error("jump page wrong");
  a_call_push: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && req.op == pcl_pkg::PCL_OP_CALL |=> push_valid && push_data == $past(program_counter))
    else $error("call push wrong");
  a_return_pop: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && req.op == pcl_pkg::PCL_OP_RET |=> pop_valid && program_counter == $past(req.ret_addr))
    else $error("return restore wrong");
  a_inc_carry: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && req.op == pcl_pkg::PCL_OP_INC |=> program_counter == $past(program_counter) + 13'h0001)
    else $error("increment wrong");
  a_upper_hold: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && (req.op == pcl_pkg::PCL_OP_NONE) |=> $stable(program_counter))
    else $error("counter moved without op");
  a_freeze_en: assert property (@(posedge clk) disable iff (!resetn)
    !clk_en |=> $stable(program_counter) && $stable(push_valid))
    else $error("state moved while disabled");
  a_small_page: assert property (@(posedge clk) disable iff (!resetn)
    s_wrlow and (PMEM_WORDS <= `PCL_SMALL_MEM_WORDS) |=> !program_counter[12])
    else $error("bit four not ignored");
  a_reset_clear: assert property (@(posedge clk)
    $rose(resetn) |-> program_counter == `PCL_PC_RESET)
    else $error("reset not cleared");

  // -------------------------------------------------------------------
  // Source checks
  // -------------------------------------------------------------------
  // Those that read the latch use it raw, except a_call_page, so they do not share the masking function
  a_call_page: assert property (@(posedge clk) disable iff (!resetn)
    s_call |=> program_counter[12:11] == $past(lat5[4:3]))
    else $error("call page wrong");
  a_page_latch: assert property (@(posedge clk) disable iff (!resetn)
    (s_jump or s_call) and (PMEM_WORDS > `PCL_SMALL_MEM_WORDS) |=> program_counter[12:11] == $past(upper_latch[4:3]))
    else $error("page bits not from latch");
  a_small_jump: assert property (@(posedge clk) disable iff (!resetn)
    (s_jump or s_call) and (PMEM_WORDS <= `PCL_SMALL_MEM_WORDS) |=> program_counter[12:11] == {1'b0, $past(upper_latch[3])})
    else $error("small page bit four used");
  a_low_write_byte: assert property (@(posedge clk) disable iff (!resetn)
    s_wrlow |=> pc_low_byte == $past(req.low_data))
    else $error("low byte not written");
  a_upper_latch: assert property (@(posedge clk) disable iff (!resetn)
    s_wrlow |=> program_counter[11:8] == $past(upper_latch[3:0]))
    else $error("upper bits not from latch");
  a_big_bit_four: assert property (@(posedge clk) disable iff (!resetn)
    s_wrlow and (PMEM_WORDS > `PCL_SMALL_MEM_WORDS) |=> program_counter[12] == $past(upper_latch[4]))
    else $error("latch bit four not copied");
  // Hidden bits move only on a decoded load or an increment carry
  a_upper_source: assert property (@(posedge clk) disable iff (!resetn)
    !$stable(program_counter[12:8]) |-> $past(clk_en) && $past(req.op) != pcl_pkg::PCL_OP_NONE)
    else $error("upper bits moved without a load");
  a_illegal_hold: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && req.op == pcl_pkg::pcl_op_type'(3'h4) |=> $stable(program_counter))
    else $error("illegal op moved counter");
  a_inc_low: assert property (@(posedge clk) disable iff (!resetn)
    s_inc and (program_counter[7:0] == 8'hff) |=> program_counter[12:8] == $past(program_counter[12:8]) + 5'h01)
    else $error("carry into upper bits lost");
  a_inc_wrap: assert property (@(posedge clk) disable iff (!resetn)
    s_inc and (program_counter == 13'h1fff) |=> program_counter == `PCL_PC_RESET)
    else $error("top address did not wrap");

  // -------------------------------------------------------------------
  // Stack checks
  // -------------------------------------------------------------------
  a_intr_vector: assert property (@(posedge clk) disable iff (!resetn)
    s_intr |=> program_counter == $past(req.vector))
    else $error("interrupt vector not loaded");
  a_intr_push: assert property (@(posedge clk) disable iff (!resetn)
    s_intr |=> push_valid && push_data == $past(program_counter))
    else $error("interrupt push wrong");
  a_push_idle: assert property (@(posedge clk) disable iff (!resetn)
    s_quiet |=> !push_valid && !pop_valid)
    else $error("stack strobe without call or return");
  a_ret_no_push: assert property (@(posedge clk) disable iff (!resetn)
    s_ret |=> !push_valid)
    else $error("return pushed the stack");
  // A held strobe must not be counted twice by the stack
  a_freeze_stack: assert property (@(posedge clk) disable iff (!resetn)
    !clk_en |=> $stable(push_data) && $stable(pop_valid))
    else $error("stack side moved while disabled");
  a_reset_state: assert property (@(posedge clk)
    $rose(resetn) |-> !push_valid && !pop_valid && push_data == `PCL_PC_RESET)
    else $error("stack side not cleared by reset");
endmodule // pcl_counter

// *** tb/pcl_stack_model.sv ***
// Return stack model beside the program counter.
// Assumes the counter's push and pop pulses count only on enabled edges.
`timescale 1ns/1ps
module pcl_stack_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic push_valid,
  input wire logic [12:0] push_data,
  input wire logic pop_valid,
  output logic [12:0] ret_top
);
  logic [12:0] mem [8];
  logic [2:0] sp;
  assign ret_top = mem[sp - 3'h1];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sp <= 3'h0;
      for (int i = 0; i < 8; i++) mem[i] <= 13'h0;
    end else if (clk_en && push_valid) begin
      mem[sp] <= push_data;
      sp <= sp + 3'h1;
    end else if (clk_en && pop_valid) sp <= sp - 3'h1;
  end
endmodule // pcl_stack_model

// *** tb/tb.sv ***
// Self-checking bench for the program counter, full and small memory.
// Assumes the stack model supplies return addresses.
`timescale 1ns/1ps
module tb;
  logic clk, resetn, clk_en, push_valid, pop_valid, e_push, e_pop;
  pcl_pkg::pcl_req_type req;
  logic [7:0] upper_latch, pc_low;
  logic [12:0] pc, pc_s, push_data, ret_top, e_pd, e_pc [2];
  int n_fail = 0, tests_run = 0;
  pcl_counter u_dut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .req(req), .upper_latch(upper_latch),
    .program_counter(pc), .pc_low_byte(pc_low), .push_valid(push_valid), .push_data(push_data), .pop_valid(pop_valid));
  pcl_counter #(.PMEM_WORDS(4096)) u_small (.clk(clk), .resetn(resetn), .clk_en(clk_en), .req(req),
    .upper_latch(upper_latch), .program_counter(pc_s), .pc_low_byte(), .push_valid(), .push_data(), .pop_valid());
  pcl_stack_model u_stack (.clk(clk), .resetn(resetn), .clk_en(clk_en), .push_valid(push_valid),
    .push_data(push_data), .pop_valid(pop_valid), .ret_top(ret_top));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [12:0] nxt(logic [12:0] p, pcl_pkg::pcl_req_type r, logic [7:0] l, bit sm);
    logic [4:0] u;
    u = sm ? {1'b0, l[3:0]} : l[4:0];
    case (r.op)
      pcl_pkg::PCL_OP_INC: return p + 13'h1;
      pcl_pkg::PCL_OP_WRLOW: return {u, r.low_data};
      pcl_pkg::PCL_OP_JUMP, pcl_pkg::PCL_OP_CALL: return {u[4:3], r.target};
      pcl_pkg::PCL_OP_RET: return r.ret_addr;
      pcl_pkg::PCL_OP_INTR: return r.vector;
      default: return p;
    endcase
  endfunction
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      e_pc = '{13'h0, 13'h0};
      {e_push, e_pop, e_pd} = '0;
    end else if (clk_en) begin
      e_push = req.op inside {pcl_pkg::PCL_OP_CALL, pcl_pkg::PCL_OP_INTR};
      e_pop = req.op == pcl_pkg::PCL_OP_RET;
      e_pd = e_pc[0];
      e_pc[0] = nxt(e_pc[0], req, upper_latch, 1'b0);
      e_pc[1] = nxt(e_pc[1], req, upper_latch, 1'b1);
    end
  end
  task automatic check(string nm, logic [12:0] seen, logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(logic [2:0] op, logic [7:0] ld, logic [7:0] lat, logic en);
    @(negedge clk);
    check("pc", pc, e_pc[0]);
    check("pc_small", pc_s, e_pc[1]);
    check("low", {5'h0, pc_low}, {5'h0, e_pc[0][7:0]});
    check("push", {12'h0, push_valid}, {12'h0, e_push});
    check("pop", {12'h0, pop_valid}, {12'h0, e_pop});
    if (e_push) check("push_data", push_data, e_pd);
    req.op = pcl_pkg::pcl_op_type'(op);
    req.low_data = ld;
    req.target = 11'($urandom);
    req.vector = 13'($urandom);
    req.ret_addr = ret_top;
    upper_latch = lat;
    clk_en = en;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #800000;
    n_fail++;
    finish_test;
  end
  initial begin
    {resetn, clk_en, upper_latch} = '0;
    req = '0;
    void'($urandom(32'h5f262317));
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    // Carry into the upper bits, then wrap from the top address
    step(3'h3, 8'hff, 8'h17, 1'b1);
    step(3'h1, 8'h00, 8'h17, 1'b1);
    step(3'h3, 8'hff, 8'hff, 1'b1);
    step(3'h1, 8'h00, 8'h00, 1'b1);
    for (int i = 0; i < 2000; i++) begin
      step(3'($urandom), 8'($urandom), 8'($urandom), ($urandom % 6) != 0);
      if (i == 1000) begin
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
      end
    end
    step(3'h0, 8'h00, 8'h00, 1'b1);
    finish_test;
  end
endmodule // tb
